// ==== verilog/tia_consts.svh ====
// constants for the timer, interrupt collection and sink-current port block
// assumes a 20 MHz system clock and 32-bit APB word addressing (index * 4)
`ifndef TIA_CONSTS_SVH
`define TIA_CONSTS_SVH

// timing: reference clock rate and timer tick period
`define TIA_CLK_MHZ       20
`define TIA_TICK_US       1
`define TIA_TICK_CYC      (`TIA_CLK_MHZ * `TIA_TICK_US)

// register indexes; byte address is index * 4
`define TIA_IDX_GPIO_MSK0 8'h04
`define TIA_IDX_GPIO_MSK3 8'h07
`define TIA_IDX_GLB_IE    8'h20
`define TIA_IDX_EP_IE     8'h21
`define TIA_IDX_PEND      8'h22
`define TIA_IDX_VEC       8'h23
`define TIA_IDX_TMR_LO    8'h24
`define TIA_IDX_TMR_HI    8'h25
`define TIA_IDX_SNK_DATA  8'h30
`define TIA_IDX_SNK_IE    8'h31
`define TIA_IDX_SNK_POL   8'h32
`define TIA_IDX_SNK_LVL0  8'h38
`define TIA_IDX_GPIO_POL  8'h50

// field positions
`define TIA_TAP_FAST      6
`define TIA_TAP_SLOW      9

// reset values
`define TIA_RST_SNK_DATA  4'hf
`define TIA_RST_LVL       4'h0

`endif

// ==== verilog/tia_pkg.sv ====
// types shared by the timer, interrupt collection and sink-current port block
// assumes the constants header is included by the design file
package tia_pkg;
	// apb request as driven by the master
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [9:0]  paddr;
		logic [31:0] pwdata;
	} tia_apb_req_s;
	// apb answer, every field from a flop
	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} tia_apb_rsp_s;
	// interrupt source numbers, lowest number served first
	typedef enum logic [3:0] {
		SRC_USB_RST, SRC_TMR_FAST, SRC_TMR_SLOW, SRC_EP0, SRC_EP1, SRC_EP2,
		SRC_EP3, SRC_EP4, SRC_SINK, SRC_GPIO, SRC_I2C
	} tia_src_e;
	typedef logic [10:0] tia_pend_t;
endpackage

// ==== verilog/tia_core.sv ====
// timer, interrupt collection and sink-current port logic behind an apb slave
// assumes all inputs synchronous to i_ref_clk; cpu acks the presented vector
`timescale 1ns/1ps
`include "tia_consts.svh"

module tia_core
	import tia_pkg::*;
(
	input  wire logic         i_ref_clk,
	input  wire logic         i_reset,
	input  wire tia_apb_req_s i_apb,
	output tia_apb_rsp_s      o_apb,
	input  wire logic         i_usb_reset,
	input  wire logic [4:0]   i_ep_event,
	input  wire logic         i_i2c_event,
	input  wire logic [31:0]  i_gpio_pin,
	input  wire logic [3:0]   i_sink_pin,
	output logic [3:0]        o_sink_pullup_en,
	output logic [3:0]        o_sink_drive_en,
	output logic [15:0]       o_sink_level,
	output logic              o_irq_req,
	output logic [3:0]        o_irq_vec,
	input  wire logic         i_irq_ack
);
	localparam int TICK_CYC = `TIA_TICK_CYC;
	logic [4:0]   div_q;           // microsecond divider
	logic         tick_q;          // one-cycle 1 MHz enable
	logic [11:0]  timer_q;         // free-running count
	logic [3:0]   hold_q;          // upper bits caught on low read
	logic [1:0]   tap_prev_q;      // previous tap levels
	logic [5:0]   glb_ie_q;        // usb rst, fast, slow, sink, gpio, i2c
	logic [4:0]   ep_ie_q;         // endpoint enables
	logic [31:0]  gpio_msk_q;      // per-pin gpio masks
	logic [3:0]   gpio_pol_q;      // per-port edge, 1 = falling
	logic [31:0]  gpio_prev_q;     // previous gpio levels
	logic [3:0]   snk_data_q;      // written sink port data
	logic [3:0]   snk_ie_q;        // per-pin sink masks
	logic [3:0]   snk_pol_q;       // per-pin edge, 1 = falling
	logic [3:0]   snk_prev_q;      // previous sink levels
	logic [15:0]  snk_lvl_q;       // 4-bit level code per pin
	tia_pend_t    pend_q;          // held requests
	logic         rd_go;           // read being answered now
	logic         wr_go;           // write taking effect now
	logic [7:0]   idx;             // register index
	logic [31:0]  rd_data;         // read mux
	logic         rd_ok;           // readable address
	logic         wr_ok;           // writable address
	logic [1:0]   tap_rise;        // rising timer taps
	logic         gpio_hit;        // merged gpio event
	logic         sink_hit;        // merged sink event
	tia_pend_t    raw_ev;          // events before enables
	tia_pend_t    ev_en;           // enable per source
	tia_pend_t    pend_clr;        // bit taken by the cpu

	// edge picker: pol 0 catches rising, 1 catches falling
	function automatic logic edge_hit(input logic prev, input logic cur, input logic pol);
		edge_hit = pol ? (prev & ~cur) : (~prev & cur);
	endfunction
	// lowest pending number wins
	function automatic logic [3:0] first_pend(input tia_pend_t p);
		first_pend = 4'h0;
		for (int k = 10; k >= 0; k--) begin
			if (p[k]) begin
				first_pend = 4'(k);
			end
		end
	endfunction

	assign idx   = i_apb.paddr[9:2];
	assign rd_go = i_apb.psel & i_apb.penable & ~o_apb.pready & ~i_apb.pwrite;
	assign wr_go = i_apb.psel & i_apb.penable & o_apb.pready & i_apb.pwrite & wr_ok;

	// microsecond tick divider
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			div_q  <= 5'h00;
			tick_q <= 1'b0;
		end else begin
			tick_q <= (div_q == 5'(TICK_CYC - 1));
			div_q  <= (div_q == 5'(TICK_CYC - 1)) ? 5'h00 : div_q + 5'h01;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			timer_q <= 12'h000;
		end else if (tick_q) begin
			timer_q <= timer_q + 12'h001;
		end
	end

	// latch upper bits on low read
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			hold_q <= 4'h0;
		end else if (rd_go && idx == `TIA_IDX_TMR_LO) begin
			hold_q <= timer_q[11:8];
		end
	end

	// read decode; write-only registers refuse reads
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_ok   = 1'b1;
		wr_ok   = 1'b1;
		unique case (idx)
			`TIA_IDX_GLB_IE:   rd_data = {26'h0, glb_ie_q};
			`TIA_IDX_EP_IE:    rd_data = {27'h0, ep_ie_q};
			`TIA_IDX_PEND: begin
				rd_data = {21'h0, pend_q};
				wr_ok   = 1'b0;
			end
			`TIA_IDX_VEC: begin
				rd_data = {27'h0, o_irq_req, o_irq_vec};
				wr_ok   = 1'b0;
			end
			`TIA_IDX_TMR_LO: begin
				rd_data = {24'h0, timer_q[7:0]};
				wr_ok   = 1'b0;
			end
			`TIA_IDX_TMR_HI: begin
				rd_data = {28'h0, hold_q};
				wr_ok   = 1'b0;
			end
			`TIA_IDX_SNK_DATA: rd_data = {28'h0, i_sink_pin};
			`TIA_IDX_GPIO_POL: rd_data = {28'h0, gpio_pol_q};
			`TIA_IDX_SNK_IE, `TIA_IDX_SNK_POL, `TIA_IDX_GPIO_MSK0, 8'h05, 8'h06,
			`TIA_IDX_GPIO_MSK3, `TIA_IDX_SNK_LVL0, 8'h39, 8'h3a, 8'h3f: rd_ok = 1'b0;
			default: begin
				rd_ok = 1'b0;
				wr_ok = 1'b0;
			end
		endcase
	end

	// apb answer: one wait cycle, then pready for one cycle; reset takes the idle path
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset && i_apb.psel && i_apb.penable && !o_apb.pready) begin
			o_apb.pready  <= 1'b1;
			o_apb.pslverr <= i_apb.pwrite ? ~wr_ok : ~rd_ok;
			o_apb.prdata  <= (i_apb.pwrite || !rd_ok) ? 32'h0 : rd_data;
		end else begin
			o_apb <= '0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			glb_ie_q <= 6'h00;
			ep_ie_q  <= 5'h00;
		end else if (wr_go && idx == `TIA_IDX_GLB_IE) begin
			glb_ie_q <= i_apb.pwdata[5:0];
		end else if (wr_go && idx == `TIA_IDX_EP_IE) begin
			ep_ie_q <= i_apb.pwdata[4:0];
		end
	end

	// gpio masks, one byte per port, and per-port polarity
	for (genvar p = 0; p < 4; p++) begin : g_gpio_cfg
		always_ff @(posedge i_ref_clk) begin
			if (i_reset) begin
				gpio_msk_q[8*p +: 8] <= 8'h00;
				gpio_pol_q[p]        <= 1'b0;
			end else if (wr_go && idx == `TIA_IDX_GPIO_MSK0 + 8'(p)) begin
				gpio_msk_q[8*p +: 8] <= i_apb.pwdata[7:0];
			end else if (wr_go && idx == `TIA_IDX_GPIO_POL) begin
				gpio_pol_q[p] <= i_apb.pwdata[p];
			end
		end
	end

	// sink port data, masks and polarity; pins map to bits 0,1,2,7
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			snk_data_q <= `TIA_RST_SNK_DATA;
			snk_ie_q   <= 4'h0;
			snk_pol_q  <= 4'h0;
		end else if (wr_go && idx == `TIA_IDX_SNK_DATA) begin
			snk_data_q <= {i_apb.pwdata[7], i_apb.pwdata[2:0]};
		end else if (wr_go && idx == `TIA_IDX_SNK_IE) begin
			snk_ie_q <= {i_apb.pwdata[7], i_apb.pwdata[2:0]};
		end else if (wr_go && idx == `TIA_IDX_SNK_POL) begin
			snk_pol_q <= {i_apb.pwdata[7], i_apb.pwdata[2:0]};
		end
	end

	// one level register per sink pin
	for (genvar s = 0; s < 4; s++) begin : g_sink_lvl
		localparam logic [7:0] LVL_IDX = `TIA_IDX_SNK_LVL0 + ((s == 3) ? 8'h07 : 8'(s));
		always_ff @(posedge i_ref_clk) begin
			if (i_reset) begin
				snk_lvl_q[4*s +: 4] <= `TIA_RST_LVL;
			end else if (wr_go && idx == LVL_IDX) begin
				snk_lvl_q[4*s +: 4] <= i_apb.pwdata[3:0];
			end
		end
	end

	// one releases the sink, pull-up drives
	// zero drops the pull-up, sink on
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			o_sink_pullup_en <= `TIA_RST_SNK_DATA;
			o_sink_drive_en  <= ~`TIA_RST_SNK_DATA;
			o_sink_level     <= 16'h0000;
		end else begin
			o_sink_pullup_en <= snk_data_q;
			o_sink_drive_en  <= ~snk_data_q;
			o_sink_level     <= snk_lvl_q;
		end
	end

	// previous levels for edge detection
	// pins tracked during reset too, so an idle-high pin gives no false edge
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			tap_prev_q  <= 2'b00;
			gpio_prev_q <= i_gpio_pin;
			snk_prev_q  <= i_sink_pin;
		end else begin
			tap_prev_q  <= {timer_q[`TIA_TAP_SLOW], timer_q[`TIA_TAP_FAST]};
			gpio_prev_q <= i_gpio_pin;
			snk_prev_q  <= i_sink_pin;
		end
	end

	// event gathering
	always_comb begin
		gpio_hit = 1'b0;
		sink_hit = 1'b0;
		// taps at bits 6 and 9
		tap_rise = {timer_q[`TIA_TAP_SLOW], timer_q[`TIA_TAP_FAST]} & ~tap_prev_q;
		// all gpio pins merge into one request, all sink pins into another
		for (int g = 0; g < 32; g++) begin
			gpio_hit |= gpio_msk_q[g] & edge_hit(gpio_prev_q[g], i_gpio_pin[g], gpio_pol_q[g/8]);
		end
		for (int s = 0; s < 4; s++) begin
			sink_hit |= snk_ie_q[s] & edge_hit(snk_prev_q[s], i_sink_pin[s], snk_pol_q[s]);
		end
		// events of every source in vector order; endpoint events come from the usb engine
		raw_ev = {i_i2c_event, gpio_hit, sink_hit, i_ep_event, tap_rise, i_usb_reset};
		// each source has its own enable
		ev_en  = {glb_ie_q[5:3], ep_ie_q, glb_ie_q[2:0]};
	end

	assign pend_clr = i_irq_ack ? tia_pend_t'(11'h001 << o_irq_vec) : 11'h000;

	// held until taken; a new event beats the clear
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			pend_q <= 11'h000;
		end else begin
			pend_q <= (pend_q & ~pend_clr) | (raw_ev & ev_en);
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			o_irq_req <= 1'b0;
			o_irq_vec <= 4'h0;
		end else begin
			o_irq_req <= |(pend_q & ~pend_clr);
			o_irq_vec <= first_pend(pend_q & ~pend_clr);
		end
	end

	// count steps by one per tick
	tick_step_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		tick_q |=> timer_q == $past(timer_q) + 12'h001)
		else $error("timer did not step on tick");
	// rising fast tap sets its request
	tap_rise_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(tap_rise[0] && glb_ie_q[1]) |=> pend_q[SRC_TMR_FAST])
		else $error("fast tap rise lost");
	tap_slow_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(!pend_q[SRC_TMR_SLOW] && !(timer_q[9] && !tap_prev_q[1])) |=> !pend_q[SRC_TMR_SLOW])
		else $error("slow tap set without bit 9 rise");
	hold_catch_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(rd_go && idx == `TIA_IDX_TMR_LO) |=> hold_q == $past(timer_q[11:8]))
		else $error("upper bits not latched");
	// high read answers from holding bits
	hold_read_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(rd_go && idx == `TIA_IDX_TMR_HI) |=> o_apb.pready && o_apb.prdata[3:0] == $past(hold_q))
		else $error("upper read not from hold");
	// pending stays until its vector is taken
	pend_keep_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(pend_q[SRC_GPIO] && !(i_irq_ack && o_irq_vec == SRC_GPIO)) |=> pend_q[SRC_GPIO])
		else $error("gpio request dropped");
	// without an ack, any pending shows a request next cycle
	req_show_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(|pend_q && !i_irq_ack) |=> o_irq_req ##0 pend_q[o_irq_vec])
		else $error("request or vector wrong");
	// data write reaches the pins two cycles on
	sink_out_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(wr_go && idx == `TIA_IDX_SNK_DATA) |=> ##1
		o_sink_pullup_en == {$past(i_apb.pwdata[7], 2), $past(i_apb.pwdata[2:0], 2)}
		&& o_sink_drive_en == ~o_sink_pullup_en)
		else $error("sink pin drive wrong");
	// masked sink pins never raise the port request
	sink_mask_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(snk_ie_q == 4'h0 && !pend_q[SRC_SINK]) |=> !pend_q[SRC_SINK])
		else $error("masked sink pin raised request");
endmodule // tia_core

// ==== bench/tia_cpu_model.sv ====
// behavioural cpu core: takes the presented interrupt vector and logs it
// assumes one clock shared with the block; the bench reads the log queues
`timescale 1ns/1ps

module tia_cpu_model
	import tia_pkg::*;
(
	input  wire logic       i_ref_clk,
	input  wire logic       i_reset,
	input  wire logic       i_irq_req,
	input  wire logic [3:0] i_irq_vec,
	input  wire logic       i_hold,
	input  wire logic       i_slow,
	output logic            o_irq_ack
);
	logic [3:0] vecs[$];   // vectors taken, in order
	time        stamps[$]; // time each vector was taken
	logic [2:0] wait_q;    // slow-mode delay count

	// one vector per ack
	// ack is raised only while a request stands, never speculatively
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			o_irq_ack <= 1'b0;
			wait_q <= 3'h0;
		end else if (o_irq_ack) begin
			// the vector seen at the ack edge is the one served
			o_irq_ack <= 1'b0;
			wait_q <= 3'h0;
			vecs.push_back(i_irq_vec);
			stamps.push_back($time);
		end else if (i_irq_req && !i_hold) begin
			// slow mode lets a request stand for several cycles
			if (!i_slow || wait_q == 3'h4) begin
				o_irq_ack <= 1'b1;
			end else begin
				wait_q <= wait_q + 3'h1;
			end
		end
	end
endmodule // tia_cpu_model

// ==== bench/timer_interrupt_and_sink_port_tb.sv ====
// bench for the timer, interrupt and sink-port block, driven over apb
// assumes the cpu model in its own file; one 20 MHz clock
`timescale 1ns/1ps
`include "tia_consts.svh"

module timer_interrupt_and_sink_port_tb
	import tia_pkg::*;
;
	logic         clk = 1'b0;   // 50 ns period
	logic         rst = 1'b1;   // sync reset
	tia_apb_req_s req = '0;     // apb master side
	tia_apb_rsp_s rsp;          // apb answer
	logic         usb_rst = 1'b0;
	logic [4:0]   ep_ev = 5'h0;
	logic         i2c_ev = 1'b0;
	logic [31:0]  gpio = 32'h0;
	logic [3:0]   spin = 4'hf;  // sink pins idle pulled up
	logic         hold = 1'b0;  // cpu refuses vectors
	logic         slow = 1'b0;  // cpu acks late
	logic [3:0]   pu, dr;
	logic [15:0]  lvl;
	logic         irq, ack;
	logic [3:0]   vec;
	logic [31:0]  rd_v;
	logic         err_v;
	int           n_fail = 0;
	int           n_compared = 0;
	logic [11:0]  c1, c2;
	time          t1, t2;
	logic [3:0]   srv_ord [5] = '{4'h0, 4'h3, 4'h5, 4'h7, 4'ha}; // priority order

	always #25 clk = ~clk;

	tia_core u_dut (.i_ref_clk(clk), .i_reset(rst), .i_apb(req), .o_apb(rsp),
		.i_usb_reset(usb_rst), .i_ep_event(ep_ev), .i_i2c_event(i2c_ev),
		.i_gpio_pin(gpio), .i_sink_pin(spin), .o_sink_pullup_en(pu),
		.o_sink_drive_en(dr), .o_sink_level(lvl), .o_irq_req(irq),
		.o_irq_vec(vec), .i_irq_ack(ack));

	tia_cpu_model u_cpu (.i_ref_clk(clk), .i_reset(rst), .i_irq_req(irq),
		.i_irq_vec(vec), .i_hold(hold), .i_slow(slow), .o_irq_ack(ack));

	// compare and count, report at once
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] x);
		n_compared++;
		if (seen !== x) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, x, seen);
		end
	endtask

	// one apb transfer; request held until pready is sampled
	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		int n;
		@(posedge clk);
		req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:{idx, 2'b00}, pwdata:wd};
		@(posedge clk);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		if (n == 20) n_fail++;
		rd_v = rsp.prdata;
		err_v = rsp.pslverr;
		req <= '0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic e);
		apb(1'b1, idx, d);
		chk("write refusal", {31'h0, err_v}, {31'h0, e});
	endtask

	task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] x,
		input logic e);
		apb(1'b0, idx, 32'h0);
		chk("read refusal", {31'h0, err_v}, {31'h0, e});
		chk(nm, rd_v, x);
	endtask

	// wait bounded for the cpu to take a vector, then compare it
	task automatic take(input logic [3:0] x);
		int n;
		n = 0;
		while (u_cpu.vecs.size() == 0 && n < 30000) begin
			@(posedge clk);
			n++;
		end
		t1 = t2;
		t2 = (n < 30000) ? u_cpu.stamps.pop_front() : 0;
		chk("vector", (n < 30000) ? {28'h0, u_cpu.vecs.pop_front()} : 32'hff, {28'h0, x});
	endtask

	// nothing may be taken for a while
	task automatic quiet();
		repeat (40) @(posedge clk);
		chk("spurious vector", u_cpu.vecs.size(), 0);
	endtask

	task automatic complete_run();
		if (n_fail == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// watchdog: the tests need well under 2 ms
	initial begin
		#4500000;
		n_fail++;
		complete_run();
	end

	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("pullups at reset", {28'h0, pu}, 32'hf);
		chk("sinks at reset", {28'h0, dr}, 32'h0);
		// register access kinds, refused places
		wr(`TIA_IDX_GLB_IE, 32'h3f, 1'b0);
		rdc("global enables", `TIA_IDX_GLB_IE, 32'h3f, 1'b0);
		wr(`TIA_IDX_EP_IE, 32'h15, 1'b0);
		rdc("endpoint enables", `TIA_IDX_EP_IE, 32'h15, 1'b0);
		wr(`TIA_IDX_TMR_LO, 32'h5, 1'b1);
		rdc("unmapped", 8'h60, 32'h0, 1'b1);
		wr(`TIA_IDX_GLB_IE, 32'h0, 1'b0);
		// split timer read stays coherent while the counter runs on
		apb(1'b0, `TIA_IDX_TMR_LO, 32'h0);
		t1 = $time;
		c1[7:0] = rd_v[7:0];
		apb(1'b0, `TIA_IDX_TMR_HI, 32'h0);
		c1[11:8] = rd_v[3:0];
		repeat (5200) @(posedge clk);
		rdc("held upper bits", `TIA_IDX_TMR_HI, {28'h0, c1[11:8]}, 1'b0);
		apb(1'b0, `TIA_IDX_TMR_LO, 32'h0);
		t2 = $time;
		c2[7:0] = rd_v[7:0];
		apb(1'b0, `TIA_IDX_TMR_HI, 32'h0);
		c2[11:8] = rd_v[3:0];
		chk("microsecond count", ((c2 - c1) - 12'((t2 - t1) / 1000) + 12'h1) <= 12'h2, 1);
		// fast tap: rising bit 6 only, so one request per 128 us
		wr(`TIA_IDX_GLB_IE, 32'h02, 1'b0);
		take(4'h1);
		take(4'h1);
		wr(`TIA_IDX_GLB_IE, 32'h04, 1'b0);
		chk("fast tap period", 32'(t2 - t1), 32'd128000);
		take(4'h2);
		wr(`TIA_IDX_GLB_IE, 32'h39, 1'b0);
		quiet();
		// simultaneous events, cpu holding off, then served by priority
		hold <= 1'b1;
		@(posedge clk);
		usb_rst <= 1'b1;
		ep_ev <= 5'h1f;
		i2c_ev <= 1'b1;
		@(posedge clk);
		usb_rst <= 1'b0;
		ep_ev <= 5'h0;
		i2c_ev <= 1'b0;
		rdc("pending set", `TIA_IDX_PEND, 32'h4a9, 1'b0);
		rdc("vector reg", `TIA_IDX_VEC, 32'h10, 1'b0);
		hold <= 1'b0;
		foreach (srv_ord[i]) take(srv_ord[i]);
		quiet();
		// sink port outputs, levels, per-pin masks and polarity
		wr(`TIA_IDX_SNK_DATA, 32'h85, 1'b0);
		// pin outputs follow the data register one edge later
		repeat (2) @(posedge clk);
		chk("pullups", {28'h0, pu}, 32'hd);
		chk("sinks", {28'h0, dr}, 32'h2);
		// ones written before pins serve as inputs
		wr(`TIA_IDX_SNK_DATA, 32'h87, 1'b0);
		wr(`TIA_IDX_SNK_LVL0, 32'h3, 1'b0);
		wr(8'h3f, 32'ha, 1'b0);
		repeat (2) @(posedge clk);
		chk("sink levels", {16'h0, lvl}, 32'ha003);
		wr(`TIA_IDX_SNK_IE, 32'h81, 1'b0);
		rdc("write-only masks", `TIA_IDX_SNK_IE, 32'h0, 1'b1);
		wr(`TIA_IDX_SNK_POL, 32'h80, 1'b0);
		wr(`TIA_IDX_GLB_IE, 32'h18, 1'b0);
		slow <= 1'b1;
		spin <= 4'he;
		quiet();
		spin <= 4'hf;
		take(4'h8);
		spin <= 4'hd;
		quiet();
		spin <= 4'h7;
		take(4'h8);
		rdc("sink pin levels", `TIA_IDX_SNK_DATA, 32'h7, 1'b0);
		// gpio: per-pin masks, per-port polarity, one shared vector
		wr(`TIA_IDX_GPIO_MSK0, 32'h01, 1'b0);
		wr(8'h05, 32'h01, 1'b0);
		wr(`TIA_IDX_GPIO_POL, 32'h2, 1'b0);
		rdc("gpio polarity", `TIA_IDX_GPIO_POL, 32'h2, 1'b0);
		gpio <= 32'h102;
		quiet();
		gpio <= 32'h103;
		take(4'h9);
		gpio <= 32'h003;
		take(4'h9);
		complete_run();
	end
endmodule // timer_interrupt_and_sink_port_tb
